/* core/pin_router_regs.vh */
`ifndef PIN_ROUTER_REGS_VH
`define PIN_ROUTER_REGS_VH
// Pin count: two byte ports plus one single-bit port.
`define NUM_PINS 17
`define NUM_ROUTED 16
// Bit positions in function_route_select_a.
`define SEL_A_UART 0
`define SEL_A_SPI 1
`define SEL_A_TWOWIRE 2
`define SEL_A_SYSCLK 3
`define SEL_A_CMP 4
`define SEL_A_CMP_ASYNC 5
// Bit positions in function_route_select_b.
`define SEL_B_CAPTURE_LO 0
`define SEL_B_CAPTURE_HI 1
`define SEL_B_ECI 3
`define SEL_B_T0 4
`define SEL_B_T1 5
`define SEL_B_ROUTER_EN 6
`define SEL_B_PULLUP_DIS 7
// Fixed UART pins.
`define UART_TX_PIN 4
`define UART_RX_PIN 5
// Reset values.
`define RST_SEL_A 8'h00
`define RST_SEL_B 8'h00
`define RST_INPUT_KIND 17'h1FFFF
`define RST_DRIVE_KIND 17'h00000
`define RST_BYPASS 16'h0000
`define RST_LATCH 17'h1FFFF
// Function numbering, in priority order.
`define FN_NONE 5'h00
`define FN_UART_TX 5'h01
`define FN_UART_RX 5'h02
`define FN_SPI_SCK 5'h03
`define FN_SPI_MISO 5'h04
`define FN_SPI_MOSI 5'h05
`define FN_SPI_NSS 5'h06
`define FN_TW_SDA 5'h07
`define FN_TW_SCL 5'h08
`define FN_CMP 5'h09
`define FN_CMP_ASYNC 5'h0A
`define FN_SYSCLK 5'h0B
`define FN_CEX0 5'h0C
`define FN_CEX1 5'h0D
`define FN_CEX2 5'h0E
`define FN_ECI 5'h0F
`define FN_T0 5'h10
`define FN_T1 5'h11
`define NUM_FN 17
`endif

/* core/route_allocator.v */
`timescale 1ns/1ns
`default_nettype none
`include "pin_router_regs.vh"
// ----------------------------------------------------------------
// Priority allocator: combinational map of function number per pin
// ----------------------------------------------------------------
module route_allocator (
  // Requests, one bit per function number
  input wire [`NUM_FN:1] fn_req,
  // Pins that may not be allocated, except the fixed UART pins
  input wire [`NUM_ROUTED-1:0] bypass,
  // Function number of each routed pin, flattened
  output reg [5*`NUM_ROUTED-1:0] pin_fn
);
  integer p;
  integer f;
  reg [`NUM_ROUTED-1:0] taken;
  reg [`NUM_FN:1] pending;
  always @* begin
    pin_fn = {(5*`NUM_ROUTED){1'b0}};
    taken = bypass;
    pending = fn_req;
    // UART owns its two pins regardless of bypass or priority.
    pending[`FN_UART_TX] = 1'b0;
    pending[`FN_UART_RX] = 1'b0;
    if (fn_req[`FN_UART_TX]) begin
      pin_fn[5*`UART_TX_PIN +: 5] = `FN_UART_TX;
      pin_fn[5*`UART_RX_PIN +: 5] = `FN_UART_RX;
      taken[`UART_TX_PIN] = 1'b1;
      taken[`UART_RX_PIN] = 1'b1;
    end
    // Each pin in ascending order takes the highest-priority pending function.
    for (p = 0; p < `NUM_ROUTED; p = p + 1) begin
      if (!taken[p]) begin
        for (f = 1; f <= `NUM_FN; f = f + 1) begin
          if (pending[f] && !taken[p]) begin
            pin_fn[5*p +: 5] = f[4:0];
            pending[f] = 1'b0;
            taken[p] = 1'b1;
          end
        end
      end
    end
  end
endmodule // route_allocator
`default_nettype wire

/* core/pin_cell.v */
`timescale 1ns/1ns
`default_nettype none
`include "pin_router_regs.vh"
// ----------------------------------------------------------------
// One port pin cell: driver, pull-up and receiver control
// ----------------------------------------------------------------
module pin_cell (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration
  input wire router_on,
  input wire digital,
  input wire push_pull,
  input wire force_od,
  input wire pullup_disable,
  // Data
  input wire out_val,
  input wire pin_in,
  // Pin and readback
  output reg pad_out,
  output reg pad_oe,
  output reg pad_pullup,
  output reg read_val
);
  reg drive_high;
  reg drive_low;
  reg open_drain;
  always @* begin
    // Disabled router or analog pin keeps the driver off.
    open_drain = force_od || !push_pull;
    drive_low = router_on && digital && !out_val;
    drive_high = router_on && digital && out_val && !open_drain;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_pullup <= 1'b1;
      read_val <= 1'b0;
    end else begin
      pad_out <= drive_high;
      pad_oe <= drive_low || drive_high;
      // Pull-up only on digital open-drain pins not pulling low.
      pad_pullup <= digital && open_drain && !pullup_disable && !drive_low;
      read_val <= digital ? pin_in : 1'b0;
    end
  end
endmodule // pin_cell
`default_nettype wire

/* core/priority_port_pin_router.v */
`timescale 1ns/1ns
`default_nettype none
`include "pin_router_regs.vh"
// What this block does
// - Serves 17 pins: two byte ports and one single-bit port, digital or analog.
// - Enabled functions in priority order take the lowest free pin.
// - Enabled UART always uses port 0 bits 4 and 5.
// - Allocation passes over assigned pins and pins set in the bypass mask.
// - Allocation skips a bypassed pin like an assigned pin, except UART, which still takes bits 4 and 5.
// - Two-wire bus claims both pins together; UART claims both pins together.
// - Unallocated pins act as ordinary port pins.
// - SPI slave select gets a pin only in four-wire mode.
// - Port reads return actual pin levels on digital pins whatever the routing.
// - Analog pins have pull-up, driver and receiver disabled.
// - Input kind bit 1 means digital, 0 means analog.
// - After reset every pin is a digital input.
// - Drive type follows the drive kind bit, also for peripheral pins other than the two-wire pins.
// - Two-wire data and clock pins are always open-drain.
// - Pull-up on open-drain pins unless disabled; push-pull pins unaffected.
// - Pull-up is off on a pin driving low.
// - Routing takes effect only once the router enable is 1.
// - With router disabled all output drivers are off.
// - Port 0 bypass 0x0C steps allocation around bits 2 and 3.
// - Select A bits: UART, SPI, two-wire, sysclk, comparator, async comparator.
// - Capture field routes none, channel 0, channels 0-1, channels 0-2.
// - Analog pins read 0; digital pins read their level.
module priority_port_pin_router (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration written by software
  input wire [7:0] function_route_select_a,
  input wire [7:0] function_route_select_b,
  input wire [7:0] port0_bypass_mask,
  input wire [7:0] port1_bypass_mask,
  input wire [16:0] pin_input_kind,
  input wire [16:0] pin_drive_kind,
  input wire [1:0] slave_select_mode_field,
  // Port latch writes
  input wire [16:0] port_latch_wdata,
  input wire [16:0] port_latch_we,
  // Peripheral outputs toward pins
  input wire uart_tx,
  input wire spi_sck_o,
  input wire spi_miso_o,
  input wire spi_mosi_o,
  input wire spi_nss_o,
  input wire spi_sck_oe,
  input wire spi_miso_oe,
  input wire spi_mosi_oe,
  input wire spi_nss_oe,
  input wire twowire_sda_o,
  input wire twowire_scl_o,
  input wire cmp_out,
  input wire cmp_async_out,
  input wire sysclk_n,
  input wire [2:0] cex_o,
  // Peripheral inputs from pins
  output reg uart_rx,
  output reg spi_sck_i,
  output reg spi_miso_i,
  output reg spi_mosi_i,
  output reg spi_nss_i,
  output reg twowire_sda_i,
  output reg twowire_scl_i,
  output reg [2:0] cex_i,
  output reg eci_in,
  output reg t0_in,
  output reg t1_in,
  // Port readback and latch
  output wire [16:0] port_read,
  output reg [16:0] port_latch,
  // Pins
  input wire [16:0] pin_in,
  output wire [16:0] pin_out,
  output wire [16:0] pin_oe,
  output wire [16:0] pin_pullup
);
  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire router_on = function_route_select_b[`SEL_B_ROUTER_EN];
  wire pullup_dis = function_route_select_b[`SEL_B_PULLUP_DIS];
  wire [1:0] cap_sel = function_route_select_b[`SEL_B_CAPTURE_HI:`SEL_B_CAPTURE_LO];
  // Four-wire slave-select modes have the upper field bit set.
  wire spi_four_wire = slave_select_mode_field[1];
  wire [`NUM_FN:1] fn_req;
  wire [5*`NUM_ROUTED-1:0] pin_fn;
  assign fn_req[`FN_UART_TX] = function_route_select_a[`SEL_A_UART];
  assign fn_req[`FN_UART_RX] = function_route_select_a[`SEL_A_UART];
  assign fn_req[`FN_SPI_SCK] = function_route_select_a[`SEL_A_SPI];
  assign fn_req[`FN_SPI_MISO] = function_route_select_a[`SEL_A_SPI];
  assign fn_req[`FN_SPI_MOSI] = function_route_select_a[`SEL_A_SPI];
  assign fn_req[`FN_SPI_NSS] = function_route_select_a[`SEL_A_SPI] && spi_four_wire;
  assign fn_req[`FN_TW_SDA] = function_route_select_a[`SEL_A_TWOWIRE];
  assign fn_req[`FN_TW_SCL] = function_route_select_a[`SEL_A_TWOWIRE];
  assign fn_req[`FN_CMP] = function_route_select_a[`SEL_A_CMP];
  assign fn_req[`FN_CMP_ASYNC] = function_route_select_a[`SEL_A_CMP_ASYNC];
  assign fn_req[`FN_SYSCLK] = function_route_select_a[`SEL_A_SYSCLK];
  assign fn_req[`FN_CEX0] = cap_sel != 2'h0;
  assign fn_req[`FN_CEX1] = cap_sel[1];
  assign fn_req[`FN_CEX2] = cap_sel == 2'h3;
  assign fn_req[`FN_ECI] = function_route_select_b[`SEL_B_ECI];
  assign fn_req[`FN_T0] = function_route_select_b[`SEL_B_T0];
  assign fn_req[`FN_T1] = function_route_select_b[`SEL_B_T1];

  // Pure combinational map; a setting change reaches the pins at the next clock edge.
  route_allocator u_alloc (
    .fn_req(fn_req),
    .bypass({port1_bypass_mask, port0_bypass_mask}),
    .pin_fn(pin_fn)
  );

  // ----------------------------------------------------------------
  // Port latches
  // ----------------------------------------------------------------
  integer b;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_latch <= `RST_LATCH;
    end else begin
      for (b = 0; b < `NUM_PINS; b = b + 1) begin
        if (port_latch_we[b]) begin
          port_latch[b] <= port_latch_wdata[b];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-pin output selection and cells
  // ----------------------------------------------------------------
  wire [16:0] out_val;
  wire [16:0] is_twowire;
  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : gen_pin
      wire [4:0] fn;
      reg val;
      if (g < `NUM_ROUTED) begin : gen_routed
        assign fn = router_on ? pin_fn[5*g +: 5] : `FN_NONE;
      end else begin : gen_plain
        assign fn = `FN_NONE;
      end
      always @* begin
        // Unassigned pins follow the port latch.
        case (fn)
          `FN_UART_TX: val = uart_tx;
          `FN_UART_RX: val = 1'b1;
          `FN_SPI_SCK: val = spi_sck_oe ? spi_sck_o : 1'b1;
          `FN_SPI_MISO: val = spi_miso_oe ? spi_miso_o : 1'b1;
          `FN_SPI_MOSI: val = spi_mosi_oe ? spi_mosi_o : 1'b1;
          `FN_SPI_NSS: val = spi_nss_oe ? spi_nss_o : 1'b1;
          `FN_TW_SDA: val = twowire_sda_o;
          `FN_TW_SCL: val = twowire_scl_o;
          `FN_CMP: val = cmp_out;
          `FN_CMP_ASYNC: val = cmp_async_out;
          `FN_SYSCLK: val = sysclk_n;
          `FN_CEX0: val = cex_o[0];
          `FN_CEX1: val = cex_o[1];
          `FN_CEX2: val = cex_o[2];
          `FN_ECI: val = 1'b1;
          `FN_T0: val = 1'b1;
          `FN_T1: val = 1'b1;
          default: val = port_latch[g];
        endcase
      end
      assign out_val[g] = val;
      assign is_twowire[g] = (fn == `FN_TW_SDA) || (fn == `FN_TW_SCL);
      // Input kind 1 is digital, 0 analog; reset value makes all digital.
      pin_cell u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .router_on(router_on),
        .digital(pin_input_kind[g]),
        .push_pull(pin_drive_kind[g]),
        .force_od(is_twowire[g]),
        .pullup_disable(pullup_dis),
        .out_val(out_val[g]),
        .pin_in(pin_in[g]),
        .pad_out(pin_out[g]),
        .pad_oe(pin_oe[g]),
        .pad_pullup(pin_pullup[g]),
        .read_val(port_read[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Peripheral inputs from routed pins
  // ----------------------------------------------------------------
  // Inputs idle high when a function has no pin, matching a pulled-up line.
  reg [`NUM_FN:1] fn_in;
  integer p;
  always @* begin
    fn_in = {`NUM_FN{1'b1}};
    for (p = 0; p < `NUM_ROUTED; p = p + 1) begin
      if (router_on && pin_fn[5*p +: 5] != `FN_NONE && pin_input_kind[p]) begin
        fn_in[pin_fn[5*p +: 5]] = pin_in[p];
      end
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_rx <= 1'b1;
      spi_sck_i <= 1'b1;
      spi_miso_i <= 1'b1;
      spi_mosi_i <= 1'b1;
      spi_nss_i <= 1'b1;
      twowire_sda_i <= 1'b1;
      twowire_scl_i <= 1'b1;
      cex_i <= 3'h7;
      eci_in <= 1'b1;
      t0_in <= 1'b1;
      t1_in <= 1'b1;
    end else begin
      uart_rx <= fn_in[`FN_UART_RX];
      spi_sck_i <= fn_in[`FN_SPI_SCK];
      spi_miso_i <= fn_in[`FN_SPI_MISO];
      spi_mosi_i <= fn_in[`FN_SPI_MOSI];
      // Three-wire mode has no slave-select pin; hold it inactive.
      spi_nss_i <= fn_in[`FN_SPI_NSS];
      twowire_sda_i <= fn_in[`FN_TW_SDA];
      twowire_scl_i <= fn_in[`FN_TW_SCL];
      cex_i <= {fn_in[`FN_CEX2], fn_in[`FN_CEX1], fn_in[`FN_CEX0]};
      eci_in <= fn_in[`FN_ECI];
      t0_in <= fn_in[`FN_T0];
      t1_in <= fn_in[`FN_T1];
    end
  end
endmodule // priority_port_pin_router
`default_nettype wire

/* tb/pin_router_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Pin router port checker
// ------------------------------
module pin_router_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [7:0] function_route_select_a,
  input wire logic [7:0] function_route_select_b,
  input wire logic [7:0] port0_bypass_mask,
  input wire logic [16:0] pin_input_kind,
  input wire logic [16:0] pin_drive_kind,
  // Peripherals and pins
  input wire logic uart_tx,
  input wire logic uart_rx,
  input wire logic twowire_sda_i,
  input wire logic t0_in,
  input wire logic [16:0] port_read,
  input wire logic [16:0] pin_in,
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [16:0] pin_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire on = function_route_select_b[6];
  wire tw = function_route_select_a[2];
  logic [16:0] pp_q, od_q, kind_q, in_q;
  // Outputs are one edge behind the configuration, so compare against last edge's settings.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {pp_q, od_q, in_q} <= '0;
      kind_q <= 17'h1FFFF;
    end else begin
      pp_q <= pin_input_kind & pin_drive_kind;
      od_q <= pin_input_kind & ~pin_drive_kind & {17{~function_route_select_b[7]}};
      kind_q <= pin_input_kind;
      in_q <= pin_in;
    end
  end
  sequence s_uart_on;
    on && function_route_select_a[0];
  endsequence
  sequence s_rx_seen;
    ##1 uart_rx == $past(pin_in[5]);
  endsequence
  a_router_off_quiet: assert property (!on |=> pin_oe == 17'h00000 && uart_rx && twowire_sda_i && t0_in)
    else $error("pins driven or inputs active while router off");
  a_analog_pin_quiet: assert property (((pin_oe | pin_pullup | port_read) & ~kind_q) == 17'h00000)
    else $error("analog pin not quiet");
  a_read_pin_level: assert property (port_read == (in_q & kind_q))
    else $error("port read differs from pin level");
  a_pullup_open_drain: assert property (!tw |=> pin_pullup == (od_q & ~pin_oe))
    else $error("pull-up state wrong");
  a_push_pull_drive: assert property (on && !tw |=> (pin_oe & pp_q) == pp_q)
    else $error("push-pull pin not driven");
  a_open_drain_low: assert property ((pin_oe & pin_out & ~pp_q) == 17'h00000)
    else $error("open-drain pin driving high");
  a_uart_tx_fixed: assert property (s_uart_on ##0 (pin_drive_kind[4] && pin_input_kind[4])
    |=> pin_oe[4] && pin_out[4] == $past(uart_tx))
    else $error("transmit not on pin 4");
  a_uart_rx_fixed: assert property (s_uart_on ##0 pin_input_kind[5] |-> s_rx_seen)
    else $error("receive not from pin 5");
  a_twowire_open_drain: assert property (on && function_route_select_a == 8'h04 && port0_bypass_mask == 8'h00
    |=> (pin_oe[1:0] & pin_out[1:0]) == 2'b00)
    else $error("two-wire pin driving high");
endmodule // pin_router_monitor
bind priority_port_pin_router pin_router_monitor i_pin_router_monitor (.*);
`default_nettype wire

/* tb/pin_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Board-side pin levels
// ------------------------------
module pin_pad_model (
  // Clock
  input wire logic clk,
  // Router side
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [16:0] pin_pullup,
  // Board drivers
  input wire logic [16:0] ext_en,
  input wire logic [16:0] ext_val,
  output logic [16:0] pin_in
);
  // A floating pin has no defined level, so it wanders every cycle instead of holding.
  logic wander = 1'b0;
  always @(posedge clk) wander <= ~wander;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | {17{wander}}));
endmodule // pin_pad_model
`default_nettype wire

/* tb/priority_port_pin_router_bench.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Pin router bench
// ------------------------------
module priority_port_pin_router_bench;
  logic clk, rst_n, uart_tx, spi_sck_o, spi_miso_o, spi_mosi_o, spi_nss_o;
  logic spi_sck_oe, spi_miso_oe, spi_mosi_oe, spi_nss_oe, twowire_sda_o, twowire_scl_o;
  logic cmp_out, cmp_async_out, sysclk_n, uart_rx, spi_sck_i, spi_miso_i, spi_mosi_i;
  logic spi_nss_i, twowire_sda_i, twowire_scl_i, eci_in, t0_in, t1_in;
  logic [1:0] slave_select_mode_field;
  logic [2:0] cex_o, cex_i;
  logic [7:0] function_route_select_a, function_route_select_b, port0_bypass_mask, port1_bypass_mask;
  logic [16:0] pin_input_kind, pin_drive_kind, port_latch_wdata, port_latch_we, port_read, port_latch;
  logic [16:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  priority_port_pin_router i_priority_port_pin_router (.*);
  pin_pad_model i_pin_pad_model (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_gpio();
    @(posedge clk);
    function_route_select_a <= 8'h00;
    function_route_select_b <= 8'h40;
    port_latch_wdata <= 17'h0A5A5;
    port_latch_we <= 17'h1FFFF;
    @(posedge clk);
    port_latch_we <= 17'h00000;
    settle();
    chk("gpio out", 17'h0A5A5, pin_out);
    chk("gpio oe", 17'h1FFFF, pin_oe);
    chk("gpio read", 17'h0A5A5, port_read);
    $display("gpio test done");
  endtask
  task automatic t_priority(input logic [1:0] mode, input logic [7:0] exp);
    @(posedge clk);
    function_route_select_a <= 8'h03;
    port0_bypass_mask <= 8'h0C;
    slave_select_mode_field <= mode;
    {uart_tx, spi_sck_o, spi_miso_o, spi_mosi_o, spi_nss_o} <= 5'b01010;
    spi_miso_oe <= 1'b0;
    settle();
    chk("priority pins", {9'h0A5, exp}, pin_out);
    chk("spi inputs", {13'h0000, 3'b111, ~mode[1]}, {13'h0000, spi_sck_i, spi_miso_i, spi_mosi_i, spi_nss_i});
    $display("priority test done");
  endtask
  task automatic t_twowire();
    @(posedge clk);
    function_route_select_a <= 8'h04;
    port0_bypass_mask <= 8'h00;
    {twowire_sda_o, twowire_scl_o} <= 2'b10;
    settle();
    chk("two-wire oe", 17'h00002, {15'h0000, pin_oe[1:0]});
    chk("two-wire pull-up", 17'h00001, {15'h0000, pin_pullup[1:0]});
    chk("two-wire inputs", 17'h00002, {15'h0000, twowire_sda_i, twowire_scl_i});
    @(posedge clk);
    function_route_select_b <= 8'hC0;
    settle();
    chk("pull-up disabled", 17'h00000, {15'h0000, pin_pullup[1:0]});
    $display("two-wire test done");
  endtask
  task automatic t_capture();
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      function_route_select_a <= 8'h00;
      function_route_select_b <= 8'h40 | 8'(n);
      cex_o <= 3'b000;
      settle();
      chk("capture pins", {14'h0000, 3'b101 & ~((3'b001 << n) - 3'b001)}, {14'h0000, pin_out[2:0]});
    end
    $display("capture test done");
  endtask
  task automatic t_analog();
    @(posedge clk);
    pin_input_kind <= 17'h1FFF7;
    port0_bypass_mask <= 8'h08;
    ext_en <= 17'h00008;
    ext_val <= 17'h00008;
    settle();
    chk("analog pin", 17'h00000, {14'h0000, port_read[3], pin_oe[3], pin_pullup[3]});
    $display("analog test done");
  endtask
  task automatic t_rx();
    @(posedge clk);
    pin_input_kind <= 17'h1FFFF;
    function_route_select_a <= 8'h01;
    pin_drive_kind <= 17'h1FFDF;
    ext_en <= 17'h00020;
    ext_val <= 17'h00000;
    settle();
    chk("receive low", 17'h00000, {16'h0000, uart_rx});
    @(posedge clk);
    ext_val <= 17'h00020;
    settle();
    chk("receive high", 17'h00001, {16'h0000, uart_rx});
    $display("receive test done");
  endtask
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("reset oe", 17'h00000, pin_oe);
    chk("reset pull-up", 17'h1FFFF, pin_pullup);
    chk("reset read", 17'h00000, port_read);
    chk("reset latch", 17'h1FFFF, port_latch);
    chk("reset inputs", 17'h0003F, {11'h000, uart_rx, spi_nss_i, twowire_sda_i, eci_in, t0_in, t1_in});
    @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk("latch after reset", 17'h1FFFF, port_latch);
    $display("reset test done");
  endtask
  task automatic t_disabled();
    chk("idle read", 17'h1FFFF, port_read);
    @(posedge clk);
    function_route_select_a <= 8'h3F;
    pin_drive_kind <= 17'h1FFFF;
    settle();
    chk("disabled oe", 17'h00000, pin_oe);
    chk("disabled inputs", 17'h0000F, {13'h0000, uart_rx, spi_sck_i, twowire_sda_i, t0_in});
    $display("disabled test done");
  endtask
  task automatic t_low_priority();
    @(posedge clk);
    function_route_select_a <= 8'h38;
    function_route_select_b <= 8'h79;
    port0_bypass_mask <= 8'h00;
    pin_drive_kind <= 17'h1FFBF;
    {cmp_out, cmp_async_out, sysclk_n, cex_o} <= 6'b101110;
    ext_en <= 17'h00040;
    ext_val <= 17'h00000;
    settle();
    chk("low priority pins", 17'h1FFB5, pin_out);
    chk("timer inputs", 17'h00036, {11'h000, cex_i, eci_in, t0_in, t1_in});
    $display("low priority test done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {uart_tx, spi_sck_o, spi_miso_o, spi_mosi_o, spi_nss_o, twowire_sda_o, twowire_scl_o} = '0;
    {spi_sck_oe, spi_miso_oe, spi_mosi_oe, spi_nss_oe} = 4'hF;
    {cmp_out, cmp_async_out, sysclk_n, cex_o, slave_select_mode_field} = '0;
    {function_route_select_a, function_route_select_b, port0_bypass_mask, port1_bypass_mask} = '0;
    {pin_drive_kind, port_latch_wdata, port_latch_we, ext_en, ext_val} = '0;
    pin_input_kind = 17'h1FFFF;
    t_reset();
    t_disabled();
    t_gpio();
    t_priority(2'b10, 8'h67);
    t_priority(2'b00, 8'hE7);
    t_twowire();
    t_capture();
    t_reset();
    t_analog();
    t_rx();
    t_low_priority();
    complete_run();
  end
endmodule // priority_port_pin_router_bench
`default_nettype wire
